// ---- tsc_mode_reg.sv ----
// mode word of the temperature sensor: storage, byte access, timer, status
//
// Functional notes
// - 16-bit read/write mode word, bytes moved high byte first.
// - High bit 7 reads 0 while converting, 1 when idle; resets to 0.
// - High bits 6:5 read-only, fixed 11 for 12-bit resolution.
// - High bits 4:3 pick consecutive faults needed: 1, 2, 4, 6.
// - High bit 2 sets alert pin active level; 0 means active low.
// - High bit 1: 1 interrupt mode, 0 comparator mode (default).
// - High bit 0: 1 shutdown, 0 continuous conversion (default).
// - Low bits 7:6 set rate 0.25, 1, 4 (default), 8 Hz.
// - Polarity 0: low bit 5 reads 1 until high-limit faults met.
// - Changed state holds until low-limit faults met, then returns idle.
// - Polarity 1 inverts the threshold status bit.
// - Event mode bit never affects the threshold status bit.
// - Wide range bit selects 13-bit formats, flagged in result bit 0.
// - General call command 06h restores reset values, aborts conversion.
`timescale 1ns/1ps
`include "tsc_defines.svh"
module tsc_mode_reg
  import tsc_pkg::*;
#(
  parameter int unsigned PERIOD0_CYC = `TSC_PERIOD0_MS * `TSC_CLK_KHZ,
  parameter int unsigned PERIOD1_CYC = `TSC_PERIOD1_MS * `TSC_CLK_KHZ,
  parameter int unsigned PERIOD2_CYC = `TSC_PERIOD2_MS * `TSC_CLK_KHZ,
  parameter int unsigned PERIOD3_CYC = `TSC_PERIOD3_MS * `TSC_CLK_KHZ
)(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  // byte access from the serial protocol engine
  input  wire logic        frame_start,
  input  wire logic        wr_byte_valid,
  input  wire logic [7:0]  wr_byte_data,
  input  wire logic        rd_byte_req,
  output logic      [7:0]  rd_byte_data,
  // general call second byte
  input  wire logic        gcall_valid,
  input  wire logic [7:0]  gcall_byte,
  // measurement path
  input  wire logic        conv_busy,
  input  wire logic        result_valid,
  input  wire logic        above_high,
  input  wire logic        below_low,
  output logic             conv_start,
  output logic             conv_abort,
  // mode outputs
  output logic             shutdown_select,
  output logic             alert_event_mode,
  output logic             output_active_level,
  output logic      [1:0]  fault_count_sel,
  output logic             wide_range_mode,
  output logic             temp_format_bit,
  output logic             threshold_state_flag
);

  logic [15:0] word;         // writable fields only
  logic [7:0]  hold_high;    // high byte waiting for its partner
  logic        byte_idx;     // 0: next byte is the high byte
  logic        conversion_done_flag;
  logic [31:0] timer;
  logic [31:0] period;
  logic        gcall_reset;
  logic        soft_clear;
  logic        commit;
  logic [15:0] read_word;
  logic [15:0] next_word;
  logic        tripped_q;

  tsc_cmp_if cmp ();

  // ------------------------------------------------------------
  // decode and selection
  // ------------------------------------------------------------
  // general call reset decode
  assign gcall_reset = gcall_valid && (gcall_byte == `TSC_GCALL_CMD);
  assign soft_clear  = !resetn || gcall_reset;
  // word commits on the low byte
  assign commit      = wr_byte_valid && byte_idx;
  assign next_word   = ({hold_high, wr_byte_data} & `TSC_WRITE_MASK) |
                       (word & ~`TSC_WRITE_MASK);

  assign shutdown_select     = word[`TSC_BIT_SHUTDOWN];
  assign alert_event_mode    = word[`TSC_BIT_EVMODE];
  assign output_active_level = word[`TSC_BIT_POL];
  assign fault_count_sel     = word[`TSC_BIT_FAULT_HI:`TSC_BIT_FAULT_LO];
  assign wide_range_mode     = word[`TSC_BIT_WIDE];
  assign temp_format_bit     = word[`TSC_BIT_WIDE];

  assign threshold_state_flag = word[`TSC_BIT_POL] ? tripped_q : !tripped_q;

  always_comb begin
    read_word = word;
    read_word[`TSC_BIT_DONE] = conversion_done_flag;
    read_word[`TSC_BIT_RES_HI:`TSC_BIT_RES_LO] = `TSC_RES_FIXED;
    read_word[`TSC_BIT_THRESH] = threshold_state_flag;
  end

  // ------------------------------------------------------------
  // threshold filter
  // ------------------------------------------------------------
  // fault count to run length
  assign cmp.need_count   = tsc_fault_need(fault_count_sel);
  assign cmp.result_valid = result_valid;
  assign cmp.above_high   = above_high;
  assign cmp.below_low    = below_low;
  assign cmp.clear        = gcall_reset;
  assign tripped_q        = cmp.tripped;

  tsc_thresh_filter u_filter (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .cmp     (cmp)
  );

  // ------------------------------------------------------------
  // mode word storage
  // ------------------------------------------------------------
  // writable fields
  always_ff @(posedge sys_clk) begin
    if (soft_clear) begin
      word <= `TSC_RESET_WORD;
    end else if (commit) begin
      word <= next_word;
    end
  end

  // byte pairing: high byte first, index restarts each frame
  always_ff @(posedge sys_clk) begin
    if (soft_clear || frame_start) begin
      byte_idx  <= 1'b0;
      hold_high <= 8'h00;
    end else if (wr_byte_valid || rd_byte_req) begin
      byte_idx <= !byte_idx;
      if (wr_byte_valid && !byte_idx) begin
        hold_high <= wr_byte_data;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (soft_clear) begin
      rd_byte_data <= 8'h00;
    end else if (rd_byte_req) begin
      rd_byte_data <= byte_idx ? read_word[7:0] : read_word[15:8];
    end
  end

  // ------------------------------------------------------------
  // conversion status and rate timer
  // ------------------------------------------------------------
  // done flag follows inverted busy
  always_ff @(posedge sys_clk) begin
    if (soft_clear) begin
      conversion_done_flag <= 1'b0;
    end else begin
      conversion_done_flag <= !conv_busy;
    end
  end

  always_comb begin
    case (word[`TSC_BIT_RATE_HI:`TSC_BIT_RATE_LO])
      2'h0:    period = PERIOD0_CYC;
      2'h1:    period = PERIOD1_CYC;
      2'h2:    period = PERIOD2_CYC;
      default: period = PERIOD3_CYC;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (soft_clear || shutdown_select) begin
      timer      <= 32'h0;
      conv_start <= 1'b0;
    end else if (timer + 32'h1 >= period) begin
      timer      <= 32'h0;
      conv_start <= 1'b1;
    end else begin
      timer      <= timer + 32'h1;
      conv_start <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      conv_abort <= 1'b0;
    end else begin
      conv_abort <= gcall_reset;
    end
  end

endmodule

// ---- tsc_defines.svh ----
// offsets, field positions, reset values and timing counts of the mode word
`ifndef TSC_DEFINES_SVH
`define TSC_DEFINES_SVH

// ------------------------------------------------------------
// field positions within the 16-bit mode word
// ------------------------------------------------------------
`define TSC_BIT_DONE       15
`define TSC_BIT_RES_HI     14
`define TSC_BIT_RES_LO     13
`define TSC_BIT_FAULT_HI   12
`define TSC_BIT_FAULT_LO   11
`define TSC_BIT_POL        10
`define TSC_BIT_EVMODE     9
`define TSC_BIT_SHUTDOWN   8
`define TSC_BIT_RATE_HI    7
`define TSC_BIT_RATE_LO    6
`define TSC_BIT_THRESH     5
`define TSC_BIT_WIDE       4

// ------------------------------------------------------------
// reset values and write masks
// ------------------------------------------------------------
`define TSC_RESET_WORD     16'h60A0
`define TSC_WRITE_MASK     16'h1FD0
`define TSC_RES_FIXED      2'h3
`define TSC_RATE_RESET     2'h2
`define TSC_GCALL_CMD      8'h06

// ------------------------------------------------------------
// timing: conversion periods in ms, clock in kHz
// ------------------------------------------------------------
`define TSC_CLK_KHZ        100000
`define TSC_PERIOD0_MS     4000
`define TSC_PERIOD1_MS     1000
`define TSC_PERIOD2_MS     250
`define TSC_PERIOD3_MS     125

`endif

// ---- tsc_pkg.sv ----
// types shared by the mode word logic
package tsc_pkg;

  typedef enum logic [1:0] {
    TSC_ST_IDLE    = 2'b01,
    TSC_ST_TRIPPED = 2'b10
  } tsc_thr_state_t;

  typedef logic [1:0] tsc_rate_t;

  // consecutive faults needed for a fault-count code
  function automatic logic [2:0] tsc_fault_need(input logic [1:0] code);
    case (code)
      2'h0:    tsc_fault_need = 3'h1;
      2'h1:    tsc_fault_need = 3'h2;
      2'h2:    tsc_fault_need = 3'h4;
      default: tsc_fault_need = 3'h6;
    endcase
  endfunction

endpackage

// ---- tsc_cmp_if.sv ----
// carrier between the mode word logic and the threshold filter
`timescale 1ns/1ps
interface tsc_cmp_if;
  logic       result_valid;
  logic       above_high;
  logic       below_low;
  logic [2:0] need_count;
  logic       clear;
  logic       tripped;

  modport ctrl (output result_valid, output above_high, output below_low,
                output need_count, output clear, input tripped);
  modport filt (input result_valid, input above_high, input below_low,
                input need_count, input clear, output tripped);
endinterface

// ---- tsc_thresh_filter.sv ----
// consecutive-fault filter with hysteresis for the threshold state
`timescale 1ns/1ps
module tsc_thresh_filter
  import tsc_pkg::*;
(
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic resetn,
  // comparison results and state
  tsc_cmp_if.filt   cmp
);

  tsc_thr_state_t state;
  tsc_thr_state_t next_state;
  logic [2:0]     run;
  logic [2:0]     next_run;
  logic           hit;
  logic [2:0]     run_inc;

  // ------------------------------------------------------------
  // condition pending in the present state
  // ------------------------------------------------------------
  // hysteresis condition select
  assign hit     = (state == TSC_ST_IDLE) ? cmp.above_high : cmp.below_low;
  assign run_inc = run + 3'h1;
  assign cmp.tripped = (state == TSC_ST_TRIPPED);

  // next state and run length
  always_comb begin
    next_state = state;
    next_run   = run;
    if (cmp.result_valid) begin
      if (!hit) begin
        next_run = 3'h0;
      end else if (run_inc >= cmp.need_count) begin
        next_run = 3'h0;
        case (state)
          TSC_ST_IDLE:    next_state = TSC_ST_TRIPPED;
          TSC_ST_TRIPPED: next_state = TSC_ST_IDLE;
          default:        next_state = TSC_ST_IDLE;
        endcase
      end else begin
        next_run = run_inc;
      end
    end
  end

  // state registers
  always_ff @(posedge sys_clk) begin
    if (!resetn || cmp.clear) begin
      state <= TSC_ST_IDLE;
      run   <= 3'h0;
    end else begin
      state <= next_state;
      run   <= next_run;
    end
  end

endmodule

// ---- tsc_mode_reg_sva.sv ----
// assertions on the mode word ports
`timescale 1ns/1ps
module tsc_mode_reg_sva (
  // clock and reset
  input wire logic       sys_clk,
  input wire logic       resetn,
  // byte access and general call
  input wire logic       frame_start,
  input wire logic       wr_byte_valid,
  input wire logic       rd_byte_req,
  input wire logic [7:0] rd_byte_data,
  input wire logic       gcall_valid,
  input wire logic [7:0] gcall_byte,
  // measurement and mode
  input wire logic       conv_busy,
  input wire logic       result_valid,
  input wire logic       above_high,
  input wire logic       conv_start,
  input wire logic       conv_abort,
  input wire logic       shutdown_select,
  input wire logic       alert_event_mode,
  input wire logic       output_active_level,
  input wire logic [1:0] fault_count_sel,
  input wire logic       wide_range_mode,
  input wire logic       temp_format_bit,
  input wire logic       threshold_state_flag
);
  logic lo_byte;
  wire  gc_rst = gcall_valid && gcall_byte == 8'h06;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // byte index: high byte first after a frame start
  always_ff @(posedge sys_clk)
    if (!resetn || frame_start) lo_byte <= 1'b0;
    else if (wr_byte_valid || rd_byte_req) lo_byte <= ~lo_byte;
  hi_byte_a: assert property (rd_byte_req && !lo_byte |=> rd_byte_data[6:0] ==
    {2'h3, fault_count_sel, output_active_level, alert_event_mode, shutdown_select})
    else $error("high byte readback wrong");
  done_flag_a: assert property (rd_byte_req && !lo_byte && $past(resetn) &&
    !$past(gcall_valid) |=> rd_byte_data[7] == !$past(conv_busy, 2))
    else $error("done flag wrong");
  abort_pulse_a: assert property (gc_rst |-> ##[1:2] conv_abort)
    else $error("no abort after general call");
  gcall_restore_a: assert property (gc_rst |=> !shutdown_select && !alert_event_mode &&
    !output_active_level && fault_count_sel == 2'h0 && !wide_range_mode && threshold_state_flag)
    else $error("general call did not restore");
  no_start_a: assert property (shutdown_select && $past(shutdown_select) |-> !conv_start)
    else $error("conversion started in shutdown");
  format_bit_a: assert property (temp_format_bit == wide_range_mode)
    else $error("format bit differs from range");
  flag_cause_a: assert property ($changed(threshold_state_flag) |-> $past(result_valid) ||
    $changed(output_active_level) || $past(gc_rst)) else $error("flag moved without cause");
  trip_one_a: assert property (fault_count_sel == 2'h0 && result_valid && above_high &&
    threshold_state_flag != output_active_level && !gc_rst && !(wr_byte_valid && lo_byte)
    |=> threshold_state_flag == output_active_level) else $error("single fault no trip");
  cover property (conv_abort);
  cover property (result_valid && above_high && fault_count_sel == 2'h3);
  cover property (rd_byte_req && lo_byte);
endmodule
bind tsc_mode_reg tsc_mode_reg_sva chk_u (.*);

// ---- tsc_meas_model.sv ----
// behavioural measurement path answering conversion starts
`timescale 1ns/1ps
module tsc_meas_model (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       resetn,
  // conversion control and wanted outcome
  input  wire logic       conv_start,
  input  wire logic       conv_abort,
  input  wire logic [1:0] cond,
  // status and result
  output logic            conv_busy = 1'b0,
  output logic            result_valid = 1'b0,
  output logic            above_high = 1'b0,
  output logic            below_low = 1'b1
);
  logic [1:0] left = 2'h0;
  // qualifiers toggle while no result is valid; stepping on the rising edge
  // keeps cond, set by the bench at the falling edge, free of races
  always @(posedge sys_clk) begin
    result_valid <= 1'b0;
    above_high <= ~above_high;
    below_low <= ~below_low;
    if (!resetn || conv_abort) begin
      conv_busy <= 1'b0;
      left <= 2'h0;
    end else if (conv_start) begin
      conv_busy <= 1'b1;
      left <= 2'h2;
    end else if (left == 2'h1) begin
      conv_busy <= 1'b0;
      result_valid <= 1'b1;
      above_high <= cond[0];
      below_low <= cond[1];
      left <= 2'h0;
    end else if (left != 2'h0) left <= left - 2'h1;
  end
endmodule

// ---- testbench.sv ----
// self-checking bench for the mode word
`timescale 1ns/1ps
module testbench;
  logic        sys_clk = 1'b0;
  logic        resetn = 1'b0;
  logic        frame_start = 1'b0;
  logic        wr_byte_valid = 1'b0;
  logic [7:0]  wr_byte_data = 8'h00;
  logic        rd_byte_req = 1'b0;
  logic        gcall_valid = 1'b0;
  logic [7:0]  gcall_byte = 8'h00;
  logic [1:0]  cond = 2'h0;
  logic [7:0]  rd_byte_data;
  logic        conv_busy, result_valid, above_high, below_low, conv_start, conv_abort;
  logic        shutdown_select, alert_event_mode, output_active_level, wide_range_mode;
  logic        temp_format_bit, threshold_state_flag;
  logic [1:0]  fault_count_sel;
  logic [15:0] word;
  int          fail_count = 0;
  int          n_compared = 0;
  int          k, n;
  always #5 sys_clk = ~sys_clk;
  tsc_mode_reg #(.PERIOD0_CYC(40), .PERIOD1_CYC(20), .PERIOD2_CYC(10), .PERIOD3_CYC(5))
    dut_u (.*);
  tsc_meas_model meas_u (.*);
  task wrap_up();
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  // high byte first, low byte commits
  task wr_word(input logic [15:0] w, input bit whole = 1'b1);
    @(negedge sys_clk) frame_start = 1'b1;
    @(negedge sys_clk) frame_start = 1'b0;
    wr_byte_valid = 1'b1;
    wr_byte_data = w[15:8];
    @(negedge sys_clk) wr_byte_data = w[7:0];
    wr_byte_valid = whole;
    @(negedge sys_clk) wr_byte_valid = 1'b0;
    @(negedge sys_clk);
  endtask
  task rd_word(output logic [15:0] w);
    @(negedge sys_clk) frame_start = 1'b1;
    @(negedge sys_clk) frame_start = 1'b0;
    rd_byte_req = 1'b1;
    @(negedge sys_clk) w[15:8] = rd_byte_data;
    @(negedge sys_clk) w[7:0] = rd_byte_data;
    rd_byte_req = 1'b0;
  endtask
  task wait_for(input bit res);
    for (int i = 0; i < 100; i++) begin
      @(posedge sys_clk) #1;
      if ((res ? result_valid : conv_start) === 1'b1) return;
    end
    fail_count++;
    wrap_up();
  endtask
  // results of one kind until the flag moves
  task count_hits(input logic [1:0] c, input int want);
    logic start;
    int   hits;
    start = threshold_state_flag;
    hits = 0;
    @(negedge sys_clk) cond = c;
    for (int i = 0; i < 400 && threshold_state_flag === start; i++) begin
      @(posedge sys_clk) #1;
      if (result_valid === 1'b1) hits++;
    end
    @(negedge sys_clk) cond = 2'h0;
    check("fault run", 16'(hits), 16'(want));
  endtask
  initial begin
    repeat (12) @(posedge sys_clk);
    @(negedge sys_clk) resetn = 1'b1;
    rd_word(word);
    check("reset word", word & 16'h7FFF, 16'h60A0);
    wr_word(16'hFFFF);
    repeat (4) @(posedge sys_clk);
    rd_word(word);
    check("all ones", word, 16'hFFD0);
    check("format", 16'(temp_format_bit), 16'h0001);
    check("mode outs", 16'({shutdown_select, alert_event_mode, output_active_level,
          fault_count_sel, wide_range_mode}), 16'h003F);
    wr_word(16'h0000, 1'b0);
    rd_word(word);
    check("lone high", word, 16'hFFD0);
    for (k = 5; k < 7; k++) begin
      @(negedge sys_clk) gcall_valid = 1'b1;
      gcall_byte = 8'(k);
      @(negedge sys_clk) gcall_valid = 1'b0;
      check("abort", 16'(conv_abort), (k == 6) ? 16'h0001 : 16'h0000);
      rd_word(word);
      check("gcall", word & 16'h7FFF, (k == 6) ? 16'h60A0 : 16'h7FD0);
    end
    for (k = 0; k < 4; k++) begin
      wr_word({3'h0, 2'(k), k[0], k[1], 9'h0C0});
      count_hits(2'h1, (k == 3) ? 6 : 1 << k);
      check("tripped", 16'(threshold_state_flag), 16'(k[0]));
      count_hits(2'h2, (k == 3) ? 6 : 1 << k);
      check("cleared", 16'(threshold_state_flag), 16'(!k[0]));
    end
    wr_word(16'h08C0);
    @(negedge sys_clk) cond = 2'h1;
    wait_for(1'b1);
    @(negedge sys_clk) cond = 2'h0;
    wait_for(1'b1);
    count_hits(2'h1, 2);
    for (k = 0; k < 4; k++) begin
      wr_word({8'h00, 2'(k), 6'h00});
      wait_for(1'b0);
      wait_for(1'b0);
      for (n = 1; n < 100; n++) begin
        @(posedge sys_clk) #1;
        if (conv_start === 1'b1) break;
      end
      check("period", 16'(n), 16'(40 >> k));
    end
    wr_word(16'h0100);
    repeat (50) @(posedge sys_clk);
    wrap_up();
  end
endmodule
